// [src/nfc_ctrl.sv]
`timescale 1ns/1ns
module nfc_ctrl #(
  parameter int SUSPEND_WAIT = nfc_pkg::SUSPEND_CYC,
  parameter int RESUME_GAP   = nfc_pkg::RESUME_CYC
) (
  input  wire logic                   mclk_i,
  input  wire logic                   reset_i,
  input  wire logic                   en_i,
  input  wire logic [2:0]             reg_addr_i,
  input  wire logic [31:0]            reg_wdata_i,
  input  wire logic                   reg_wr_i,
  input  wire logic                   reg_rd_i,
  output logic [31:0]                 reg_rdata_o,
  output logic [nfc_pkg::AW-1:0]      faddr_o,
  output logic [nfc_pkg::DW-1:0]      fdq_o,
  output logic                        fdq_oe_o,
  input  wire logic [nfc_pkg::DW-1:0] fdq_i,
  output logic                        fce_n_o,
  output logic                        fwe_n_o,
  output logic                        foe_n_o
);
  typedef enum logic [5:0] {
    S_IDLE  = 6'h01,
    S_HOLDW = 6'h02,
    S_WR    = 6'h04,
    S_RDA   = 6'h08,
    S_RDB   = 6'h10,
    S_SUSW  = 6'h20
  } nfc_st_e;

  localparam logic [11:0] SUSP_LD = 12'(SUSPEND_WAIT);
  localparam logic [11:0] GAP_LD = 12'(RESUME_GAP);
  localparam int TB = nfc_pkg::TOGGLE_STATUS_BIT;
  localparam int FB = nfc_pkg::TIME_LIMIT_FAIL_BIT;

  function automatic logic [2:0] n_writes(nfc_pkg::nfc_op_e op);
    case (op)
      nfc_pkg::OP_RESET, nfc_pkg::OP_SUSP,
      nfc_pkg::OP_RESUME, nfc_pkg::OP_SADD: n_writes = 3'h1;
      nfc_pkg::OP_ID: n_writes = 3'h3;
      nfc_pkg::OP_PROG: n_writes = 3'h4;
      nfc_pkg::OP_CHIP, nfc_pkg::OP_SECT: n_writes = 3'h6;
      default: n_writes = 3'h0;
    endcase
  endfunction

  // Address and data of write number k of a command sequence.
  function automatic nfc_pkg::nfc_wr_s seq_word(
    nfc_pkg::nfc_op_e op, logic [2:0] k,
    logic [nfc_pkg::AW-1:0] a, logic [nfc_pkg::DW-1:0] d);
    nfc_pkg::nfc_wr_s w;
    w.addr = nfc_pkg::ADDR_UNLOCK1;
    w.data = nfc_pkg::D_UNLOCK1;
    if (op == nfc_pkg::OP_RESET) begin
      w = '{addr: a, data: nfc_pkg::D_RESET};
    end else if (op == nfc_pkg::OP_SUSP) begin
      w = '{addr: a, data: nfc_pkg::D_SUSPEND};
    end else if (op == nfc_pkg::OP_RESUME) begin
      w = '{addr: a, data: nfc_pkg::D_RESUME};
    end else if (op == nfc_pkg::OP_SADD) begin
      w = '{addr: a, data: nfc_pkg::D_SECTOR};
    end else begin
      case (k)
        3'h1, 3'h4: w = '{addr: nfc_pkg::ADDR_UNLOCK2,
                          data: nfc_pkg::D_UNLOCK2};
        3'h2: w.data = (op == nfc_pkg::OP_ID) ? nfc_pkg::D_IDENT :
                       (op == nfc_pkg::OP_PROG) ? nfc_pkg::D_PROG :
                       nfc_pkg::D_ERASE_SETUP;
        3'h3: if (op == nfc_pkg::OP_PROG) w = '{addr: a, data: d};
        3'h5: w = (op == nfc_pkg::OP_CHIP) ?
                  '{addr: nfc_pkg::ADDR_UNLOCK1,
                    data: nfc_pkg::D_CHIP} :
                  '{addr: a, data: nfc_pkg::D_SECTOR};
        default: w = w;
      endcase
    end
    return w;
  endfunction

  nfc_bus_if bus ();

  nfc_bus_engine u_eng (
    .mclk_i   (mclk_i),
    .reset_i  (reset_i),
    .en_i     (en_i),
    .bus      (bus.eng),
    .faddr_o  (faddr_o),
    .fdq_o    (fdq_o),
    .fdq_oe_o (fdq_oe_o),
    .fdq_i    (fdq_i),
    .fce_n_o  (fce_n_o),
    .fwe_n_o  (fwe_n_o),
    .foe_n_o  (foe_n_o)
  );

  nfc_st_e                st_r;
  nfc_pkg::nfc_op_e       op_r, op_in;
  nfc_pkg::nfc_wr_s       cur;
  logic [2:0]             step_r;
  logic                   chk_r, fail_r, id_r, pend_r, susp_r, refused_r;
  logic [11:0]            wait_r, gap_r;
  logic [nfc_pkg::AW-1:0] addr_r, prev_wa_r;
  logic [nfc_pkg::DW-1:0] wdata_r, first_r, rdata_r, prev_wd_r;
  logic                   cmd_go, op_ok, accept, wr_last;
  logic                   poll_same, poll_fail;

  assign op_in = nfc_pkg::nfc_op_e'(reg_wdata_i[3:0]);
  assign cmd_go = en_i && reg_wr_i && (reg_addr_i == nfc_pkg::REG_CMD);
  assign op_ok = (op_in != nfc_pkg::OP_NONE) &&
                 (op_in inside {nfc_pkg::OP_READ, nfc_pkg::OP_RESET,
                   nfc_pkg::OP_ID, nfc_pkg::OP_PROG, nfc_pkg::OP_CHIP,
                   nfc_pkg::OP_SECT, nfc_pkg::OP_SADD, nfc_pkg::OP_POLL,
                   nfc_pkg::OP_SUSP, nfc_pkg::OP_RESUME});
  assign accept = cmd_go && (st_r == S_IDLE) && op_ok &&
                  (!fail_r || op_in == nfc_pkg::OP_RESET);
  assign cur = seq_word(op_r, step_r, addr_r, wdata_r);
  assign wr_last = (st_r == S_WR) && bus.done &&
                   (step_r == n_writes(op_r) - 3'h1);
  // Toggle-bit polling: two reads agree on bit six when the flash is idle.
  assign poll_same = (st_r == S_RDB) && bus.done &&
                     (first_r[TB] == bus.rdata[TB]);
  assign poll_fail = (st_r == S_RDB) && bus.done && !poll_same &&
                     bus.rdata[FB] && chk_r;

  assign bus.req = (st_r == S_WR) || (st_r == S_RDA) || (st_r == S_RDB);
  assign bus.wr = (st_r == S_WR);
  assign bus.addr = (st_r == S_WR) ? cur.addr : addr_r;
  assign bus.wdata = cur.data;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      st_r    <= S_IDLE;
      op_r    <= nfc_pkg::OP_NONE;
      step_r  <= 3'h0;
      chk_r   <= 1'b0;
      wait_r  <= 12'h000;
      first_r <= 8'h00;
    end else if (en_i) begin
      unique case (st_r)
        S_IDLE: if (accept) begin
          op_r   <= op_in;
          step_r <= 3'h0;
          chk_r  <= 1'b0;
          if (n_writes(op_in) == 3'h0) begin
            st_r <= S_RDA;
          end else if (op_in == nfc_pkg::OP_SUSP && gap_r != 12'h000) begin
            st_r <= S_HOLDW;
          end else begin
            st_r <= S_WR;
          end
        end
        S_HOLDW: if (gap_r == 12'h000) st_r <= S_WR;
        S_WR: if (bus.done) begin
          if (!wr_last) begin
            step_r <= step_r + 3'h1;
          end else if (op_r == nfc_pkg::OP_PROG ||
                       op_r == nfc_pkg::OP_CHIP) begin
            st_r <= S_RDA;
          end else if (op_r == nfc_pkg::OP_SUSP) begin
            wait_r <= SUSP_LD;
            st_r   <= S_SUSW;
          end else begin
            st_r <= S_IDLE;
          end
        end
        S_RDA: if (bus.done) begin
          first_r <= bus.rdata;
          st_r    <= (op_r == nfc_pkg::OP_READ) ? S_IDLE : S_RDB;
        end
        S_RDB: if (bus.done) begin
          if (poll_same || poll_fail) begin
            st_r <= S_IDLE;
          end else begin
            chk_r <= chk_r | bus.rdata[FB];
            st_r  <= S_RDA;
          end
        end
        S_SUSW: begin
          if (wait_r == 12'h000) st_r <= S_IDLE;
          else wait_r <= wait_r - 12'h001;
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      fail_r    <= 1'b0;
      id_r      <= 1'b0;
      pend_r    <= 1'b0;
      susp_r    <= 1'b0;
      refused_r <= 1'b0;
    end else if (en_i) begin
      if (cmd_go) refused_r <= !accept;
      if (poll_fail) fail_r <= 1'b1;
      else if (wr_last && op_r == nfc_pkg::OP_RESET) fail_r <= 1'b0;
      if (wr_last && op_r == nfc_pkg::OP_ID) id_r <= 1'b1;
      else if (wr_last && op_r == nfc_pkg::OP_RESET) id_r <= 1'b0;
      if (wr_last) begin
        pend_r <= (op_r == nfc_pkg::OP_SECT || op_r == nfc_pkg::OP_SADD ||
                   (op_r == nfc_pkg::OP_SUSP && pend_r));
      end else if (poll_same && !susp_r) begin
        pend_r <= 1'b0;
      end
      if (st_r == S_SUSW && wait_r == 12'h000) susp_r <= 1'b1;
      else if (wr_last && op_r == nfc_pkg::OP_RESUME) susp_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      gap_r <= 12'h000;
    end else if (en_i) begin
      if (wr_last && op_r == nfc_pkg::OP_RESUME) gap_r <= GAP_LD;
      else if (gap_r != 12'h000) gap_r <= gap_r - 12'h001;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      addr_r    <= 19'h00000;
      wdata_r   <= 8'h00;
      rdata_r   <= 8'h00;
      prev_wa_r <= 19'h00000;
      prev_wd_r <= 8'h00;
    end else if (en_i) begin
      if (reg_wr_i && st_r == S_IDLE && reg_addr_i == nfc_pkg::REG_ADDR)
        addr_r <= reg_wdata_i[nfc_pkg::AW-1:0];
      if (reg_wr_i && st_r == S_IDLE && reg_addr_i == nfc_pkg::REG_WDATA)
        wdata_r <= reg_wdata_i[nfc_pkg::DW-1:0];
      if (bus.done && (st_r == S_RDB ||
                       (st_r == S_RDA && op_r == nfc_pkg::OP_READ)))
        rdata_r <= bus.rdata;
      if (st_r == S_WR && bus.done) begin
        prev_wa_r <= bus.addr;
        prev_wd_r <= bus.wdata;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      reg_rdata_o <= 32'h00000000;
    end else if (en_i) begin
      reg_rdata_o <= 32'h00000000;
      if (reg_rd_i) begin
        case (reg_addr_i)
          nfc_pkg::REG_CMD: reg_rdata_o <= 32'(op_r);
          nfc_pkg::REG_ADDR: reg_rdata_o <= 32'(addr_r);
          nfc_pkg::REG_WDATA: reg_rdata_o <= 32'(wdata_r);
          nfc_pkg::REG_STATUS: reg_rdata_o <= 32'({gap_r != 12'h000,
            refused_r, susp_r, pend_r, id_r, fail_r, st_r != S_IDLE});
          nfc_pkg::REG_RDATA: reg_rdata_o <= 32'(rdata_r);
          default: reg_rdata_o <= 32'h00000000;
        endcase
      end
    end
  end

  a_unlock_order: assert property (@(posedge mclk_i)
    disable iff (reset_i || !en_i)
    (st_r == S_WR && step_r == 3'h1) |->
      bus.addr == nfc_pkg::ADDR_UNLOCK2 && bus.wdata == nfc_pkg::D_UNLOCK2
      && prev_wa_r == nfc_pkg::ADDR_UNLOCK1
      && prev_wd_r == nfc_pkg::D_UNLOCK1)
    else $error("second unlock write not preceded by first");
  a_fail_lockout: assert property (@(posedge mclk_i)
    disable iff (reset_i || !en_i)
    (cmd_go && st_r == S_IDLE && fail_r && op_in != nfc_pkg::OP_RESET)
      |=> st_r == S_IDLE && refused_r)
    else $error("command other than reset taken after failure");
  a_prog_order: assert property (@(posedge mclk_i)
    disable iff (reset_i || !en_i)
    (st_r == S_WR && op_r == nfc_pkg::OP_PROG && step_r == 3'h3) |->
      bus.addr == addr_r && bus.wdata == wdata_r
      && prev_wd_r == nfc_pkg::D_PROG)
    else $error("program data write out of order");
  a_chip_tail: assert property (@(posedge mclk_i)
    disable iff (reset_i || !en_i)
    (st_r == S_WR && op_r == nfc_pkg::OP_CHIP && bus.done && wr_last)
      |-> bus.wdata == nfc_pkg::D_CHIP
      && prev_wd_r == nfc_pkg::D_UNLOCK2 ##1 st_r == S_RDA)
    else $error("chip erase sequence ended wrongly");
  a_sect_tail: assert property (@(posedge mclk_i)
    disable iff (reset_i || !en_i)
    (st_r == S_WR && op_r == nfc_pkg::OP_SECT && step_r == 3'h5) |->
      bus.addr == addr_r && bus.wdata == nfc_pkg::D_SECTOR
      && prev_wa_r == nfc_pkg::ADDR_UNLOCK2)
    else $error("sector erase final write wrong");
  a_resume_gap: assert property (@(posedge mclk_i)
    disable iff (reset_i || !en_i)
    (wr_last && op_r == nfc_pkg::OP_RESUME) |=>
      gap_r == GAP_LD ##1 (st_r != S_WR || op_r != nfc_pkg::OP_SUSP))
    else $error("suspend issued inside resume gap");
  a_suspend_gap: assert property (@(posedge mclk_i)
    disable iff (reset_i || !en_i)
    (st_r == S_WR && op_r == nfc_pkg::OP_SUSP) |-> gap_r == 12'h000)
    else $error("suspend write while resume gap runs");
  c_prog_done: cover property (@(posedge mclk_i)
    poll_same && op_r == nfc_pkg::OP_PROG);
  c_poll_fail: cover property (@(posedge mclk_i) poll_fail);
  c_suspended: cover property (@(posedge mclk_i) $rose(susp_r));
endmodule

// [src/nfc_pkg.sv]
package nfc_pkg;
  localparam int AW = 19;
  localparam int DW = 8;
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_ACCESS_NS = 90;
  localparam int T_SUSPEND_US = 20;
  localparam int T_RESUME_US = 400;
  localparam int SYNC_STAGES = 3;
  localparam int RD_WAIT_CYC =
    (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SUSPEND_CYC =
    (T_SUSPEND_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESUME_CYC =
    (T_RESUME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [AW-1:0] ADDR_UNLOCK1 = 19'h00555;
  localparam logic [AW-1:0] ADDR_UNLOCK2 = 19'h002aa;
  localparam logic [DW-1:0] D_UNLOCK1 = 8'haa;
  localparam logic [DW-1:0] D_UNLOCK2 = 8'h55;
  localparam logic [DW-1:0] D_RESET = 8'hf0;
  localparam logic [DW-1:0] D_IDENT = 8'h90;
  localparam logic [DW-1:0] D_PROG = 8'ha0;
  localparam logic [DW-1:0] D_ERASE_SETUP = 8'h80;
  localparam logic [DW-1:0] D_CHIP = 8'h10;
  localparam logic [DW-1:0] D_SECTOR = 8'h30;
  localparam logic [DW-1:0] D_SUSPEND = 8'hb0;
  localparam logic [DW-1:0] D_RESUME = 8'h30;

  localparam int TOGGLE_STATUS_BIT = 6;
  localparam int TIME_LIMIT_FAIL_BIT = 5;

  localparam logic [2:0] REG_CMD = 3'h0;
  localparam logic [2:0] REG_ADDR = 3'h1;
  localparam logic [2:0] REG_WDATA = 3'h2;
  localparam logic [2:0] REG_STATUS = 3'h3;
  localparam logic [2:0] REG_RDATA = 3'h4;

  typedef enum logic [3:0] {
    OP_NONE   = 4'h0,
    OP_READ   = 4'h1,
    OP_RESET  = 4'h2,
    OP_ID     = 4'h3,
    OP_PROG   = 4'h4,
    OP_CHIP   = 4'h5,
    OP_SECT   = 4'h6,
    OP_SADD   = 4'h7,
    OP_POLL   = 4'h8,
    OP_SUSP   = 4'h9,
    OP_RESUME = 4'ha
  } nfc_op_e;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] data;
  } nfc_wr_s;
endpackage

// [src/nfc_bus_if.sv]
`timescale 1ns/1ns
interface nfc_bus_if;
  logic                   req;
  logic                   wr;
  logic [nfc_pkg::AW-1:0] addr;
  logic [nfc_pkg::DW-1:0] wdata;
  logic                   done;
  logic [nfc_pkg::DW-1:0] rdata;
  modport ctl (output req, wr, addr, wdata, input done, rdata);
  modport eng (input req, wr, addr, wdata, output done, rdata);
endinterface

// [src/nfc_bus_engine.sv]
`timescale 1ns/1ns
module nfc_bus_engine #(
  parameter int RD_WAIT = nfc_pkg::RD_WAIT_CYC + nfc_pkg::SYNC_STAGES
) (
  input  wire logic                   mclk_i,
  input  wire logic                   reset_i,
  input  wire logic                   en_i,
  nfc_bus_if.eng                      bus,
  output logic [nfc_pkg::AW-1:0]      faddr_o,
  output logic [nfc_pkg::DW-1:0]      fdq_o,
  output logic                        fdq_oe_o,
  input  wire logic [nfc_pkg::DW-1:0] fdq_i,
  output logic                        fce_n_o,
  output logic                        fwe_n_o,
  output logic                        foe_n_o
);
  typedef enum logic [5:0] {
    E_IDLE  = 6'h01,
    E_SETUP = 6'h02,
    E_PULSE = 6'h04,
    E_HOLD  = 6'h08,
    E_RWAIT = 6'h10,
    E_END   = 6'h20
  } nfc_eng_e;

  localparam logic [3:0] WAIT_LD = 4'(RD_WAIT);

  nfc_eng_e               st_r;
  logic                   wr_r;
  logic [3:0]             cnt_r;
  logic [nfc_pkg::DW-1:0] s1_r, s2_r, s3_r, rdata_r;

  // Data pins come from the flash, so they cross into this clock.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      s1_r <= 8'h00;
      s2_r <= 8'h00;
      s3_r <= 8'h00;
    end else if (en_i) begin
      s1_r <= fdq_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      st_r     <= E_IDLE;
      wr_r     <= 1'b0;
      cnt_r    <= 4'h0;
      rdata_r  <= 8'h00;
      faddr_o  <= 19'h00000;
      fdq_o    <= 8'h00;
      fdq_oe_o <= 1'b0;
      fce_n_o  <= 1'b1;
      fwe_n_o  <= 1'b1;
      foe_n_o  <= 1'b1;
    end else if (en_i) begin
      unique case (st_r)
        E_IDLE: if (bus.req) begin
          faddr_o  <= bus.addr;
          fdq_o    <= bus.wdata;
          fdq_oe_o <= bus.wr;
          wr_r     <= bus.wr;
          foe_n_o  <= bus.wr;
          fce_n_o  <= 1'b0;
          cnt_r    <= WAIT_LD;
          st_r     <= E_SETUP;
        end
        E_SETUP: begin
          fwe_n_o <= ~wr_r;
          st_r    <= wr_r ? E_PULSE : E_RWAIT;
        end
        E_PULSE: begin
          fwe_n_o <= 1'b1;
          st_r    <= E_HOLD;
        end
        E_HOLD: begin
          fce_n_o  <= 1'b1;
          fdq_oe_o <= 1'b0;
          st_r     <= E_END;
        end
        E_RWAIT: begin
          if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
          end else if (s2_r == s3_r) begin
            rdata_r <= s3_r;
            fce_n_o <= 1'b1;
            foe_n_o <= 1'b1;
            st_r    <= E_END;
          end
        end
        E_END: st_r <= E_IDLE;
        default: st_r <= E_IDLE;
      endcase
    end
  end

  assign bus.done  = (st_r == E_END);
  assign bus.rdata = rdata_r;

  a_write_oe_high: assert property (@(posedge mclk_i)
    disable iff (reset_i || !en_i)
    !fwe_n_o |-> (foe_n_o && !fce_n_o && fdq_oe_o))
    else $error("write strobe low while output strobe low");
  a_we_pulse: assert property (@(posedge mclk_i)
    disable iff (reset_i || !en_i)
    $fell(fwe_n_o) |-> !fce_n_o ##1 (fwe_n_o && !fce_n_o && fdq_oe_o))
    else $error("write pulse not framed by chip select and data");
  a_read_bound: assert property (@(posedge mclk_i)
    disable iff (reset_i || !en_i)
    (st_r == E_IDLE && bus.req && !bus.wr) |-> ##[6:12] bus.done)
    else $error("read cycle did not finish in time");
  c_write: cover property (@(posedge mclk_i) $rose(fwe_n_o));
  c_read: cover property (@(posedge mclk_i) bus.done && !wr_r);
endmodule

// [sim/nfc_flash_model.sv]
`timescale 1ns/1ns
module nfc_flash_model #(
  parameter logic [7:0] MFR_CODE  = 8'h3c, // Arbitrary value.
  parameter logic [7:0] DEV_CODE  = 8'h7e, // Arbitrary value.
  parameter int         PROG_CYC  = 20,
  parameter int         ERASE_CYC = 300,
  parameter int         WIN_CYC   = 500,
  parameter int         SUSP_CYC  = 2
) (
  input  wire logic [18:0] addr_i,
  input  wire logic [7:0]  dq_i,
  input  wire logic        ce_n_i,
  input  wire logic        we_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        fail_i,
  output logic      [7:0]  dq_o
);
  logic [7:0]  mem [logic [18:0]];
  logic [18:0] la;
  logic [18:0] pa;
  logic [7:0]  pd;
  logic [7:0]  pat  = 8'h00;
  logic [7:0]  sect = 8'h00;
  bit          idm, bp, be, win, chip, sp, susp, fail, tog;
  int          step = 0;
  int          tmr  = 0;

  function automatic logic [7:0] rd(input logic [18:0] a);
    if (bp) return {~pd[7], tog, fail, 5'h00};
    if (chip || be || win || sp)
      return {1'b0, tog, 2'b00, !win, tog, 2'b00};
    if (susp && sect[a[18:16]]) return {5'h10, tog, 2'b00};
    if (idm) return a[0] ? DEV_CODE : MFR_CODE;
    return mem.exists(a) ? mem[a] : 8'hff;
  endfunction

  task automatic cmd(input logic [18:0] a, input logic [7:0] d);
    if (fail || idm) begin
      if (d == 8'hf0) fail = 0;
      if (d == 8'hf0) bp = 0;
      if (d == 8'hf0) idm = 0;
      return;
    end
    if (bp || chip || be || sp) begin
      if (be && d == 8'hb0) begin
        sp = 1;
        tmr = SUSP_CYC;
      end
      return;
    end
    if (win) begin
      win = (d == 8'h30);
      susp = (d == 8'hb0);
      tmr = win ? WIN_CYC : 0;
      if (win) sect[a[18:16]] = 1'b1;
      if (!win && !susp) sect = 8'h00;
      return;
    end
    case (step)
      0: begin
        if (susp && d == 8'h30) begin
          susp = 0;
          be = 1;
          tmr = ERASE_CYC;
        end
        step = (a == 19'h555 && d == 8'haa) ? 1 : 0;
      end
      1: step = (a == 19'h2aa && d == 8'h55) ? 2 : 0;
      2: begin
        idm = (a == 19'h555 && d == 8'h90);
        step = (a != 19'h555) ? 0 : (d == 8'ha0) ? 3 :
               (d == 8'h80 && !susp) ? 4 : 0;
      end
      3: begin
        pa = a;
        pd = d;
        bp = 1;
        fail = fail_i;
        tmr = fail_i ? 0 : PROG_CYC;
        step = 0;
      end
      4: step = (a == 19'h555 && d == 8'haa) ? 5 : 0;
      5: step = (a == 19'h2aa && d == 8'h55) ? 6 : 0;
      default: begin
        chip = (a == 19'h555 && d == 8'h10);
        win = (d == 8'h30);
        tmr = chip ? ERASE_CYC : win ? WIN_CYC : 0;
        if (win) sect[a[18:16]] = 1'b1;
        step = 0;
      end
    endcase
  endtask

  task automatic fin;
    if (win) begin
      win = 0;
      be = 1;
      tmr = ERASE_CYC;
    end else if (sp || be) begin
      if (!sp) foreach (mem[k])
        if (sect[k[18:16]]) mem[k] = 8'hff;
      if (!sp) sect = 8'h00;
      susp = sp;
      sp = 0;
      be = 0;
    end else if (bp) begin
      mem[pa] = (mem.exists(pa) ? mem[pa] : 8'hff) & pd;
      bp = 0;
    end else begin
      mem.delete();
      chip = 0;
    end
  endtask

  initial dq_o = 8'h00;
  always @(negedge we_n_i) if (!ce_n_i && oe_n_i) la = addr_i;
  always @(posedge we_n_i) if (!ce_n_i && oe_n_i) cmd(la, dq_i);
  // Chip select and output strobe fall in one time step; let both settle.
  always @(negedge oe_n_i) #1 if (!ce_n_i) tog = !tog;
  // Released pins show a pattern that moves every 100 ns, never stale data.
  always #10 dq_o = (!ce_n_i && !oe_n_i) ? rd(addr_i) : pat;
  always #100 begin
    pat = pat + 8'h35;
    if (tmr > 0) begin
      tmr = tmr - 1;
      if (tmr == 0) fin();
    end
  end
endmodule

// [sim/nor_flash_command_state_machine_bench.sv]
`timescale 1ns/1ns
module nor_flash_command_state_machine_bench;
  logic        mclk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic        fail_inj = 1'b0;
  logic        rd_seen = 1'b0;
  logic [2:0]  reg_addr_i = 3'h0;
  logic [31:0] reg_wdata_i = 32'h0;
  logic [31:0] reg_rdata_o, last_rd;
  logic [18:0] faddr_o, a;
  logic [7:0]  fdq_o, flash_q, d, e;
  logic        fdq_oe_o, fce_n_o, fwe_n_o, foe_n_o;
  wire  [7:0]  dq_bus = fdq_oe_o ? fdq_o : flash_q;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  int          n_errors = 0;
  int          checked = 0;
  int          cyc = 0;
  int          i;

  nfc_ctrl #(.SUSPEND_WAIT(4), .RESUME_GAP(8)) uut (
    .mclk_i(mclk_i), .reset_i(reset_i), .en_i(1'b1),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .faddr_o(faddr_o), .fdq_o(fdq_o), .fdq_oe_o(fdq_oe_o), .fdq_i(dq_bus),
    .fce_n_o(fce_n_o), .fwe_n_o(fwe_n_o), .foe_n_o(foe_n_o));
  nfc_flash_model flash (.addr_i(faddr_o), .dq_i(dq_bus), .ce_n_i(fce_n_o),
    .we_n_i(fwe_n_o), .oe_n_i(foe_n_o), .fail_i(fail_inj), .dq_o(flash_q));

  initial forever #50 mclk_i = ~mclk_i;

  task automatic test_done;
    if (n_errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] ev, input logic [31:0] m);
    if (m !== 32'h0) begin
      checked++;
      if ((reg_rdata_o & m) !== ev) begin
        n_errors++;
        $display("MISMATCH reg_rdata_o expected %h seen %h", ev,
                 reg_rdata_o & m);
      end
    end
  endtask

  always @(posedge mclk_i) begin
    rd_seen <= reg_rd_i;
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      test_done();
    end
  end
  always @(negedge mclk_i) if (rd_seen) begin
    last_rd = reg_rdata_o;
    chk_reg(exp_q.pop_front(), msk_q.pop_front());
  end

  task automatic bus(input logic w, input logic r, input logic [2:0] ix,
                     input logic [31:0] v);
    reg_wr_i <= w;
    reg_rd_i <= r;
    reg_addr_i <= ix;
    reg_wdata_i <= v;
    @(posedge mclk_i);
  endtask
  task automatic wr(input logic [2:0] ix, input logic [31:0] v);
    bus(1'b1, 1'b0, ix, v);
    bus(1'b0, 1'b0, ix, v);
  endtask
  task automatic rd(input logic [2:0] ix, input logic [31:0] ev,
                    input logic [31:0] m);
    exp_q.push_back(ev);
    msk_q.push_back(m);
    bus(1'b0, 1'b1, ix, 32'h0);
    bus(1'b0, 1'b0, ix, 32'h0);
  endtask
  // Issues one opcode and polls the busy flag until it drops.
  task automatic op(input logic [3:0] o, input logic [18:0] fa,
                    input logic [7:0] fd);
    int k;
    k = 0;
    wr(3'h1, {13'h0, fa});
    wr(3'h2, {24'h0, fd});
    wr(3'h0, {28'h0, o});
    do begin
      rd(3'h3, 32'h0, 32'h0);
      k++;
    end while (last_rd[0] !== 1'b0 && k < 5000);
  endtask
  task automatic rbyte(input logic [18:0] fa, input logic [7:0] ev);
    op(nfc_pkg::OP_READ, fa, 8'h00);
    rd(3'h4, {24'h0, ev}, 32'hff);
  endtask

  initial begin
    void'($urandom(32'h2f37));
    repeat (16) @(posedge mclk_i);
    reset_i <= 1'b0;
    rd(3'h3, 32'h0, 32'h7f);
    rd(3'h7, 32'h0, 32'hffffffff);
    op(nfc_pkg::OP_ID, 19'h0, 8'h00);
    for (i = 0; i < 4; i++)
      rbyte({18'h0, i[0]}, i[0] ? flash.DEV_CODE : flash.MFR_CODE);
    op(nfc_pkg::OP_PROG, 19'h0, 8'h00);
    rbyte(19'h0, flash.MFR_CODE);
    a = 19'($urandom());
    op(nfc_pkg::OP_RESET, a, 8'h00);
    rbyte(19'h0, 8'hff);
    for (i = 0; i < 3; i++) begin
      a = {3'h1, 16'($urandom())};
      d = 8'($urandom());
      e = 8'($urandom());
      op(nfc_pkg::OP_PROG, a, d);
      rbyte(a, d);
      op(nfc_pkg::OP_PROG, a, e);
      rbyte(a, d & e);
    end
    wr(3'h0, 32'hf);
    rd(3'h3, 32'h20, 32'h20);
    op(nfc_pkg::OP_PROG, 19'h30010, 8'h00);
    op(nfc_pkg::OP_PROG, 19'h00010, 8'h5a);
    op(nfc_pkg::OP_PROG, 19'h40010, 8'h00);
    op(nfc_pkg::OP_SECT, 19'h30010, 8'h00);
    rd(3'h3, 32'h8, 32'h8);
    op(nfc_pkg::OP_RESET, 19'h0, 8'h00);
    repeat (600) @(posedge mclk_i);
    rbyte(19'h30010, 8'h00);
    op(nfc_pkg::OP_SECT, a, 8'h00);
    op(nfc_pkg::OP_SADD, 19'h30010, 8'h00);
    repeat (520) @(posedge mclk_i);
    op(nfc_pkg::OP_SADD, 19'h00010, 8'h00);
    op(nfc_pkg::OP_POLL, a, 8'h00);
    rbyte(a, 8'hff);
    rbyte(19'h30010, 8'hff);
    rbyte(19'h00010, 8'h5a);
    op(nfc_pkg::OP_SECT, 19'h40010, 8'h00);
    repeat (520) @(posedge mclk_i);
    op(nfc_pkg::OP_SUSP, 19'h40010, 8'h00);
    rd(3'h3, 32'h10, 32'h10);
    op(nfc_pkg::OP_READ, 19'h40010, 8'h00);
    rd(3'h4, 32'h80, 32'ha0);
    rbyte(19'h00010, 8'h5a);
    op(nfc_pkg::OP_CHIP, 19'h00010, 8'h00);
    op(nfc_pkg::OP_PROG, 19'h00010, 8'h50);
    rbyte(19'h00010, 8'h50);
    op(nfc_pkg::OP_RESUME, 19'h40010, 8'h00);
    op(nfc_pkg::OP_SUSP, 19'h40010, 8'h00);
    rd(3'h3, 32'h10, 32'h10);
    op(nfc_pkg::OP_RESUME, 19'h40010, 8'h00);
    op(nfc_pkg::OP_POLL, 19'h40010, 8'h00);
    rbyte(19'h40010, 8'hff);
    op(nfc_pkg::OP_CHIP, 19'h0, 8'h00);
    rbyte(19'h00010, 8'hff);
    fail_inj <= 1'b1;
    op(nfc_pkg::OP_PROG, 19'h00020, 8'h00);
    rd(3'h3, 32'h2, 32'h2);
    wr(3'h0, {28'h0, nfc_pkg::OP_READ});
    rd(3'h3, 32'h20, 32'h20);
    fail_inj <= 1'b0;
    op(nfc_pkg::OP_RESET, 19'h0, 8'h00);
    rd(3'h3, 32'h0, 32'h22);
    rbyte(19'h00020, 8'hff);
    test_done();
  end
endmodule
